/* File: aom_pkg.sv */
package aom_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYC = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int WIRE_TIME_NS = 1000;
  localparam int WIRE_CYC = (WIRE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DUTY_SHIFT = 3;
  localparam int AW = 12;
  localparam int CNT_W = 24;
  localparam int CTRL_W = 18;
  localparam logic [AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [AW-1:0] OFS_HYST = 12'h004;
  localparam logic [AW-1:0] OFS_GEAR = 12'h008;
  localparam logic [AW-1:0] OFS_MEAS = 12'h00C;
  localparam logic [AW-1:0] OFS_VERIF = 12'h010;
  localparam logic [AW-1:0] OFS_PITCH = 12'h014;
  localparam logic [AW-1:0] OFS_STATUS = 12'h018;
  localparam logic [AW-1:0] OFS_FREQ = 12'h01C;
  localparam logic [AW-1:0] OFS_TRIP = 12'h020;
  localparam logic [AW-1:0] OFS_REL = 12'h024;
  localparam logic [AW-1:0] OFS_SPEED = 12'h040;
  localparam int CF_ARR = 0;
  localparam int CF_LINAX = 3;
  localparam int CF_LINSNS = 4;
  localparam int CF_DIR_EN = 5;
  localparam int CF_QUAL = 6;
  localparam int CF_THR = 8;
  localparam int CF_LEGACY = 11;
  localparam int CF_NPN = 12;
  localparam int CF_NC = 13;
  localparam int CF_4WIRE = 14;
  localparam int CF_SINCOS = 15;
  localparam int CF_ANA_DIS = 16;
  localparam int CF_TTL = 17;
  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h0_0000;
  localparam logic [6:0] HYST_RST = 7'h05;
  localparam logic [6:0] HYST_MAX = 7'h63;
  localparam logic [15:0] GEAR_RST = 16'h0100;
  localparam logic [15:0] RES_RST = 16'h0001;
  localparam logic [15:0] PITCH_RST = 16'h0001;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [15:0] SEC_PER_MIN = 16'h003C;
  localparam logic [15:0] MILLI = 16'h03E8;
  localparam logic [7:0] PERCENT = 8'h64;
  localparam logic [2:0] LEGACY_MAX = 3'h3;
  localparam int ST_UNDER = 0;
  localparam int ST_DIR = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_VALID = 3;
  localparam int ST_FLT = 4;
  localparam int ST_SUPPLY = 8;
  localparam int ST_ANALOG = 9;
  typedef enum logic [2:0] {ARR_ENC, ARR_PROX, ARR_ENC_PROX, ARR_PROX2, ARR_ENC2} aom_arr_t;
  typedef enum logic [1:0] {QUAL_BIDIR, QUAL_CW, QUAL_CCW} aom_qual_t;
  typedef enum logic [1:0] {CV_TRIP_GO, CV_TRIP_WAIT, CV_REL_GO, CV_REL_WAIT} aom_cv_t;
endpackage

/* File: aom_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// restoring divider, one quotient bit per cycle; a zero divisor gives all ones
module aom_divider (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [47:0] num_i,
  input wire logic [23:0] den_i,
  output logic done_o,
  output logic [47:0] quo_o
);
  logic [24:0] rem_r;
  logic [23:0] den_r;
  logic [5:0] step_r;
  logic run_r;
  logic [24:0] trial;
  logic ge;
  assign trial = {rem_r[23:0], quo_o[47]};
  assign ge = trial >= {1'b0, den_r};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rem_r <= '0;
      den_r <= '0;
      step_r <= '0;
      run_r <= 1'b0;
      done_o <= 1'b0;
      quo_o <= '0;
    end else begin
      done_o <= run_r && step_r == 6'h2F;
      if (start_i) begin
        rem_r <= '0;
        den_r <= den_i;
        quo_o <= num_i;
        step_r <= '0;
        run_r <= 1'b1;
      end else if (run_r) begin
        rem_r <= ge ? trial - {1'b0, den_r} : trial;
        quo_o <= {quo_o[46:0], ge};
        step_r <= step_r + 6'h01;
        run_r <= step_r != 6'h2F;
      end
    end
  end
endmodule
`default_nettype wire

/* File: aom_pulse_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module aom_pulse_chan #(
  parameter int GATE_CYCLES = aom_pkg::GATE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic gate_i,
  input wire logic en_i,
  input wire logic quad_i,
  input wire logic inv_i,
  input wire logic compl_i,
  input wire logic a_i,
  input wire logic b_i,
  output logic [aom_pkg::CNT_W-1:0] count_o,
  output logic dir_o,
  output logic phase_err_o,
  output logic duty_err_o,
  output logic wire_err_o
);
  import aom_pkg::*;
  localparam logic [31:0] DUTY_LO = 32'(GATE_CYCLES >> DUTY_SHIFT);
  localparam logic [31:0] DUTY_HI = 32'(GATE_CYCLES - (GATE_CYCLES >> DUTY_SHIFT));
  localparam logic [7:0] WIRE_LIM = 8'(WIRE_CYC);
  logic a, a_q, b_q, rise, ph_now, wr_now;
  logic [CNT_W-1:0] cnt_r;
  logic [31:0] hi_r;
  logic [7:0] eq_r;
  logic ph_r, wr_r;
  // proximity polarity folded in here so only real target passes count
  assign a = a_i ^ inv_i;
  assign rise = en_i & a & ~a_q;
  assign ph_now = en_i & quad_i & (a ^ a_q) & (b_i ^ b_q);
  // complementary pair stuck equal too long means a broken wire
  assign wr_now = en_i & compl_i & ~quad_i & (eq_r >= WIRE_LIM);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      eq_r <= '0;
      cnt_r <= '0;
      hi_r <= '0;
      ph_r <= 1'b0;
      wr_r <= 1'b0;
      count_o <= '0;
      dir_o <= 1'b0;
      phase_err_o <= 1'b0;
      duty_err_o <= 1'b0;
      wire_err_o <= 1'b0;
    end else begin
      a_q <= a;
      b_q <= b_i;
      eq_r <= (a_i != b_i) ? '0 : (eq_r >= WIRE_LIM) ? eq_r : eq_r + 8'h01;
      if (quad_i && rise) dir_o <= b_i;
      if (gate_i) begin
        count_o <= cnt_r;
        phase_err_o <= ph_r | ph_now;
        wire_err_o <= wr_r | wr_now;
        duty_err_o <= quad_i && cnt_r > 1 && (hi_r < DUTY_LO || hi_r > DUTY_HI);
        cnt_r <= CNT_W'(rise);
        hi_r <= 32'(en_i & a);
        ph_r <= 1'b0;
        wr_r <= 1'b0;
      end else begin
        if (rise && !(&cnt_r)) cnt_r <= cnt_r + 1'b1;
        if (en_i && a) hi_r <= hi_r + 32'h0000_0001;
        if (ph_now) ph_r <= 1'b1;
        if (wr_now) wr_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: aom_top.sv */
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module aom_top #(
  parameter int GATE_CYCLES = aom_pkg::GATE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [aom_pkg::AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sensor1_a_i,
  input wire logic sensor1_b_i,
  input wire logic sensor2_a_i,
  input wire logic sensor2_b_i,
  input wire logic enc_supply_ok_i,
  input wire logic sincos_ok_i,
  input wire logic limit_select_bit0_i,
  input wire logic limit_select_bit1_i,
  input wire logic limit_select_bit2_i,
  output logic under_limit_o,
  output logic direction_o,
  output logic fault_o
);
  import aom_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [6:0] hyst_r;
  logic [15:0] gear_r, meas_r, verif_r, pitch_r;
  logic [15:0] speed_r [8];
  logic [CNT_W-1:0] trip_r, rel_r;
  logic [31:0] gcnt_r;
  logic gate_r, gate_d_r, valid_r, conv_ok_r, over_r;
  logic [3:0] flt_r;
  aom_cv_t cv_r;

  // configuration fields
  aom_arr_t arr;
  aom_qual_t qual;
  logic lin_ax, lin_sns, has_enc, two_sns, prox_inv;
  logic [2:0] thr_n;
  assign arr = aom_arr_t'(ctrl_r[CF_ARR +: 3]);
  assign qual = aom_qual_t'(ctrl_r[CF_QUAL +: 2]);
  assign lin_ax = ctrl_r[CF_LINAX];
  assign lin_sns = lin_ax & ctrl_r[CF_LINSNS];
  assign has_enc = arr != ARR_PROX && arr != ARR_PROX2;
  assign two_sns = arr == ARR_ENC_PROX || arr == ARR_PROX2 || arr == ARR_ENC2;
  assign prox_inv = ctrl_r[CF_NPN] ^ ctrl_r[CF_NC];

  // threshold selection
  logic [2:0] sel;
  assign thr_n = (ctrl_r[CF_LEGACY] && ctrl_r[CF_THR +: 3] > LEGACY_MAX) ?
    LEGACY_MAX : ctrl_r[CF_THR +: 3];
  assign sel = (thr_n == 3'h0) ? 3'h0 :
    (thr_n == 3'h1) ? {2'h0, limit_select_bit0_i} :
    (thr_n < 3'h4) ? {1'b0, limit_select_bit1_i, limit_select_bit0_i} :
    {limit_select_bit2_i, limit_select_bit1_i, limit_select_bit0_i};

  // APB slave, answers in the second access cycle
  logic acc, wr_acc, spd_hit, rd_hit;
  logic [2:0] spd_idx;
  logic [31:0] rd_data, status;
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
  assign spd_hit = paddr_i[AW-1:5] == OFS_SPEED[AW-1:5] && paddr_i[1:0] == 2'h0;
  assign spd_idx = paddr_i[4:2];

  logic sup_flt, ana_flt;
  assign sup_flt = has_enc & ctrl_r[CF_TTL] & ~enc_supply_ok_i;
  // analog check only when enabled; otherwise phase/duty checks remain as the plain check
  assign ana_flt = has_enc & ctrl_r[CF_SINCOS] & ~ctrl_r[CF_ANA_DIS] & ~sincos_ok_i;

  logic [CNT_W-1:0] c1, c2;
  always_comb begin
    status = '0;
    status[ST_UNDER] = under_limit_o;
    status[ST_DIR] = direction_o;
    status[ST_FAULT] = fault_o;
    status[ST_VALID] = valid_r;
    status[ST_FLT +: 4] = flt_r;
    status[ST_SUPPLY] = sup_flt;
    status[ST_ANALOG] = ana_flt;
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    if (paddr_i == OFS_CTRL) rd_data = 32'(ctrl_r);
    else if (paddr_i == OFS_HYST) rd_data = 32'(hyst_r);
    else if (paddr_i == OFS_GEAR) rd_data = 32'(gear_r);
    else if (paddr_i == OFS_MEAS) rd_data = 32'(meas_r);
    else if (paddr_i == OFS_VERIF) rd_data = 32'(verif_r);
    else if (paddr_i == OFS_PITCH) rd_data = 32'(pitch_r);
    else if (paddr_i == OFS_STATUS) rd_data = status;
    else if (paddr_i == OFS_FREQ) rd_data = 32'(c1);
    else if (paddr_i == OFS_TRIP) rd_data = 32'(trip_r);
    else if (paddr_i == OFS_REL) rd_data = 32'(rel_r);
    else if (spd_hit) rd_data = 32'(speed_r[spd_idx]);
    else rd_hit = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= acc;
      prdata_o <= (acc && !pwrite_i) ? rd_data : '0;
      pslverr_o <= acc & ~rd_hit;
    end
  end

  // status and measured registers ignore writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
      hyst_r <= HYST_RST;
      gear_r <= GEAR_RST;
      meas_r <= RES_RST;
      verif_r <= RES_RST;
      pitch_r <= PITCH_RST;
      for (int i = 0; i < 8; i++) speed_r[i] <= SPEED_RST;
    end else if (wr_acc) begin
      if (paddr_i == OFS_CTRL) ctrl_r <= pwdata_i[CTRL_W-1:0];
      else if (paddr_i == OFS_HYST) hyst_r <= pwdata_i[6:0];
      else if (paddr_i == OFS_GEAR) gear_r <= pwdata_i[15:0];
      else if (paddr_i == OFS_MEAS) meas_r <= pwdata_i[15:0];
      else if (paddr_i == OFS_VERIF) verif_r <= pwdata_i[15:0];
      else if (paddr_i == OFS_PITCH) pitch_r <= pwdata_i[15:0];
      else if (spd_hit) speed_r[spd_idx] <= pwdata_i[15:0];
    end
  end

  // speed to frequency conversion, recomputed continuously
  logic [15:0] spd;
  logic [31:0] sp_res;
  logic [47:0] num_trip, num_rel, div_num, quo;
  logic [23:0] den_trip, div_den;
  logic [6:0] hy;
  logic div_start, div_done;
  assign spd = speed_r[sel];
  assign sp_res = spd * meas_r;
  assign hy = (hyst_r > HYST_MAX) ? HYST_MAX : hyst_r;
  always_comb begin
    if (!lin_ax) begin
      num_trip = 48'(sp_res);
      den_trip = 24'(SEC_PER_MIN);
    end else if (!lin_sns) begin
      num_trip = 48'(sp_res) * 48'(MILLI);
      den_trip = 24'(SEC_PER_MIN * 32'(pitch_r));
    end else begin
      num_trip = 48'(spd) * 48'(MILLI);
      den_trip = 24'(meas_r);
    end
  end
  assign num_rel = 48'(trip_r) * 48'(PERCENT - 8'(hy));
  assign div_start = cv_r == CV_TRIP_GO || cv_r == CV_REL_GO;
  assign div_num = (cv_r == CV_TRIP_GO) ? num_trip : num_rel;
  assign div_den = (cv_r == CV_TRIP_GO) ? den_trip : 24'(PERCENT);

  aom_divider u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(div_start),
    .num_i(div_num),
    .den_i(div_den),
    .done_o(div_done),
    .quo_o(quo)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cv_r <= CV_TRIP_GO;
      trip_r <= '0;
      rel_r <= '0;
      conv_ok_r <= 1'b0;
    end else begin
      case (cv_r)
        CV_TRIP_GO: cv_r <= CV_TRIP_WAIT;
        CV_TRIP_WAIT: if (div_done) begin
          trip_r <= (|quo[47:CNT_W]) ? '1 : quo[CNT_W-1:0];
          cv_r <= CV_REL_GO;
        end
        CV_REL_GO: cv_r <= CV_REL_WAIT;
        CV_REL_WAIT: if (div_done) begin
          rel_r <= quo[CNT_W-1:0];
          conv_ok_r <= 1'b1;
          cv_r <= CV_TRIP_GO;
        end
        default: cv_r <= CV_TRIP_GO;
      endcase
    end
  end

  // gate interval
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gcnt_r <= '0;
      gate_r <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      gate_r <= gcnt_r == 32'(GATE_CYCLES - 2);
      gcnt_r <= (gcnt_r == 32'(GATE_CYCLES - 1)) ? '0 : gcnt_r + 32'h0000_0001;
      gate_d_r <= gate_r;
    end
  end

  // pulse channels: sensor 1 primary, sensor 2 verification
  logic q1, q2, dir1, ph1, ph2, du1, du2, wi1, wi2;
  assign q1 = has_enc;
  assign q2 = arr == ARR_ENC2;
  aom_pulse_chan #(.GATE_CYCLES(GATE_CYCLES)) u_ch1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .gate_i(gate_r),
    .en_i(1'b1),
    .quad_i(q1),
    .inv_i(~q1 & prox_inv),
    .compl_i(ctrl_r[CF_4WIRE]),
    .a_i(sensor1_a_i),
    .b_i(sensor1_b_i),
    .count_o(c1),
    .dir_o(dir1),
    .phase_err_o(ph1),
    .duty_err_o(du1),
    .wire_err_o(wi1)
  );
  aom_pulse_chan #(.GATE_CYCLES(GATE_CYCLES)) u_ch2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .gate_i(gate_r),
    .en_i(two_sns),
    .quad_i(q2),
    .inv_i(~q2 & prox_inv),
    .compl_i(ctrl_r[CF_4WIRE]),
    .a_i(sensor2_a_i),
    .b_i(sensor2_b_i),
    .count_o(c2),
    .dir_o(),
    .phase_err_o(ph2),
    .duty_err_o(du2),
    .wire_err_o(wi2)
  );

  // cross check: c1*x*gear against c2*y*256, tolerance one eighth plus quantisation
  logic [15:0] rx, ry;
  logic [55:0] lhs, rhs, dif, tol;
  logic cong;
  assign rx = lin_sns ? meas_r : verif_r;
  assign ry = lin_sns ? verif_r : meas_r;
  assign lhs = 56'(c1) * 56'(rx) * 56'(gear_r);
  assign rhs = (56'(c2) * 56'(ry)) << 8;
  assign dif = (lhs > rhs) ? lhs - rhs : rhs - lhs;
  assign tol = (lhs >> DUTY_SHIFT) + (rhs >> DUTY_SHIFT) + (56'(rx) * 56'(gear_r) << 1);
  // a dead sensor while the other counts shows here as missing sensor
  assign cong = two_sns & (dif > tol);

  // decision at gate, hysteresis and direction qualifier
  logic dir_ok, fault_nxt;
  assign dir_ok = !has_enc || qual == QUAL_BIDIR ||
    (qual == QUAL_CW && !dir1) || (qual == QUAL_CCW && dir1);
  assign fault_nxt = valid_r & ((|flt_r) | sup_flt | ana_flt);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_r <= 1'b0;
      over_r <= 1'b0;
      flt_r <= '0;
      under_limit_o <= 1'b0;
      direction_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      if (gate_d_r && conv_ok_r) begin
        valid_r <= 1'b1;
        if (!dir_ok) over_r <= 1'b0;
        else if (c1 > trip_r) over_r <= 1'b1;
        else if (c1 < rel_r) over_r <= 1'b0;
        flt_r <= {cong, wi1 | wi2, du1 | du2, ph1 | ph2};
      end
      under_limit_o <= valid_r & ~over_r;
      direction_o <= ctrl_r[CF_DIR_EN] & has_enc & dir1;
      // a sensor fault alone leaves the under-limit output untouched
      fault_o <= fault_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: aom_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module aom_asserts #(
  parameter int GATE_CYCLES = aom_pkg::GATE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sensor1_b_i,
  input wire logic under_limit_o,
  input wire logic direction_o,
  input wire logic fault_o
);
  logic [31:0] rst_cnt_r;
  logic [31:0] chg_cnt_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // cycles since reset release and since the last move of the under-limit output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_cnt_r <= 32'h0000_0000;
      chg_cnt_r <= 32'h0000_0000;
    end else begin
      rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
      chg_cnt_r <= $changed(under_limit_o) ? 32'h0000_0000 : chg_cnt_r + 32'h0000_0001;
    end
  end

  reset_clear_a: assert property (
    $rose(rst_n_i) |-> !(under_limit_o || fault_o || direction_o) ##1 !(under_limit_o || fault_o))
    else $error("outputs not clear after reset");
  first_meas_a: assert property (
    (under_limit_o || fault_o) |-> rst_cnt_r >= 32'(GATE_CYCLES))
    else $error("output set before first gate completed");
  under_gate_a: assert property (
    $changed(under_limit_o) |-> chg_cnt_r >= 32'(GATE_CYCLES - 2))
    else $error("under-limit output moved twice within one gate");
  ccw_dir_a: assert property (
    $rose(direction_o) |-> $past(sensor1_b_i, 2) || $past(sensor1_b_i, 3) || $past(sensor1_b_i, 4))
    else $error("direction rose without counterclockwise phase");
  ready_wait_a: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready one cycle after access");
  ready_pulse_a: assert property (
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (
    pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_idle_a: assert property (
    !pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside answer");
endmodule

bind aom_top aom_asserts #(.GATE_CYCLES(GATE_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sensor1_b_i(sensor1_b_i),
  .under_limit_o(under_limit_o), .direction_o(direction_o), .fault_o(fault_o));
`default_nettype wire

/* File: aom_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// quadrature encoder; lines hold their level when the shaft stops
module aom_enc_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic ccw_i,
  input wire logic glitch_i,
  input wire logic [7:0] quarter_i,
  output logic a_o,
  output logic b_o
);
  logic [1:0] ph_r = 2'h0;
  logic [7:0] cnt_r = 8'h00;
  logic [1:0] step;
  // a glitch steps two phases at once, so both lines toggle together
  assign step = glitch_i ? 2'h2 : (ccw_i ? 2'h3 : 2'h1);
  always_ff @(posedge clk_i) begin
    if (run_i && cnt_r >= quarter_i - 8'h01) begin
      cnt_r <= 8'h00;
      ph_r <= ph_r + step;
    end else if (run_i) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign a_o = ph_r[0] ^ ph_r[1];
  assign b_o = ph_r[1];
endmodule
`default_nettype wire

/* File: aom_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aom_pkg::*;
  localparam int GATE = 2000;
  localparam logic [15:0] SEL_ROWS [16] = '{16'h0070, 16'h1060, 16'h1011, 16'h2062, 16'h3051,
    16'h3073, 16'h7000, 16'h7011, 16'h7022, 16'h7033, 16'h7044, 16'h7055, 16'h7066, 16'h7077,
    16'h7173, 16'h3062};
  localparam logic [15:0] DIR_ROWS [6] = '{16'h0000, 16'h0101, 16'h1000, 16'h1111, 16'h2101,
    16'h2010};
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [AW-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic s1_a;
  logic s1_b;
  logic supply_ok = 1'h1;
  logic sincos_ok = 1'h1;
  logic [2:0] sel = 3'h0;
  logic under_limit_o;
  logic direction_o;
  logic fault_o;
  logic run = 1'h0;
  logic ccw = 1'h0;
  logic glitch = 1'h0;
  logic [7:0] quarter = 8'h05;
  logic err_seen;
  logic [31:0] scratch;
  int fails = 0;
  int tests_run = 0;

  always #4 clk_i = ~clk_i;

  aom_enc_model enc_u (.clk_i(clk_i), .run_i(run), .ccw_i(ccw), .glitch_i(glitch),
    .quarter_i(quarter), .a_o(s1_a), .b_o(s1_b));
  aom_top #(.GATE_CYCLES(GATE)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sensor1_a_i(s1_a), .sensor1_b_i(s1_b),
    .sensor2_a_i(1'h0), .sensor2_b_i(1'h0), .enc_supply_ok_i(supply_ok),
    .sincos_ok_i(sincos_ok), .limit_select_bit0_i(sel[0]), .limit_select_bit1_i(sel[1]),
    .limit_select_bit2_i(sel[2]), .under_limit_o(under_limit_o), .direction_o(direction_o),
    .fault_o(fault_o));

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; returns just after one
  task automatic apb(input logic wr, input logic [AW-1:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata_o;
    err_seen = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [AW-1:0] addr, input logic [31:0] data);
    apb(1'h1, addr, data, scratch);
  endtask

  task automatic rd(input logic [AW-1:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    apb(1'h0, addr, 32'h0000_0000, v);
    check(v, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_reset();
    check(32'({under_limit_o, direction_o, fault_o}), 32'h0000_0000);
    rd(OFS_HYST, 32'h0000_0005);
    rd(OFS_GEAR, 32'h0000_0100);
    rd(OFS_MEAS, 32'h0000_0001);
    rd(OFS_VERIF, 32'h0000_0001);
    rd(OFS_PITCH, 32'h0000_0001);
    rd(OFS_SPEED + 12'h01C, 32'h0000_0000);
    rd(12'h030, 32'h0000_0000);
    check(32'(err_seen), 32'h0000_0001);
    wr(OFS_TRIP, 32'hFFFF_FFFF);
    rd(OFS_TRIP, 32'h0000_0000);
    check(32'({under_limit_o, fault_o}), 32'h0000_0000);
  endtask

  task automatic t_hyst();
    wr(OFS_MEAS, 32'h0000_003C);
    wr(OFS_SPEED, 32'h0000_0032);
    wr(OFS_HYST, 32'h0000_0032);
    settle(400);
    rd(OFS_TRIP, 32'h0000_0032);
    rd(OFS_REL, 32'h0000_0019);
    quarter <= 8'h05;
    run <= 1'h1;
    settle(2 * GATE + 20);
    check(32'(under_limit_o), 32'h0000_0000);
    quarter <= 8'h0C;
    settle(2 * GATE + 20);
    check(32'(under_limit_o), 32'h0000_0000);
    quarter <= 8'h32;
    settle(2 * GATE + 20);
    check(32'(under_limit_o), 32'h0000_0001);
    rd(OFS_FREQ, 32'h0000_000A);
    quarter <= 8'h0C;
    settle(2 * GATE + 20);
    check(32'(under_limit_o), 32'h0000_0001);
  endtask

  task automatic formula(input logic [31:0] ctrl, spd, meas, pitch, hyst, trip, rel);
    wr(OFS_CTRL, ctrl);
    wr(OFS_SPEED, spd);
    wr(OFS_MEAS, meas);
    wr(OFS_PITCH, pitch);
    wr(OFS_HYST, hyst);
    settle(400);
    rd(OFS_TRIP, trip);
    rd(OFS_REL, rel);
  endtask

  task automatic t_select();
    wr(OFS_MEAS, 32'h0000_003C);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_SPEED + 12'(4 * i), 32'h0000_000A + 32'(i));
    end
    foreach (SEL_ROWS[k]) begin
      wr(OFS_CTRL, 32'({SEL_ROWS[k][8], SEL_ROWS[k][14:12], 8'h00}));
      sel <= SEL_ROWS[k][6:4];
      settle(400);
      rd(OFS_TRIP, 32'(SEL_ROWS[k][3:0]) + 32'h0000_000A);
    end
    sel <= 3'h0;
  endtask

  task automatic t_dir();
    wr(OFS_SPEED, 32'h0000_0032);
    wr(OFS_HYST, 32'h0000_0005);
    quarter <= 8'h05;
    foreach (DIR_ROWS[k]) begin
      wr(OFS_CTRL, 32'({DIR_ROWS[k][13:12], 6'h20}));
      ccw <= DIR_ROWS[k][8];
      settle(2 * GATE + 20);
      check(32'(under_limit_o), 32'(DIR_ROWS[k][4]));
      check(32'(direction_o), 32'(DIR_ROWS[k][0]));
    end
    wr(OFS_CTRL, 32'h0000_0000);
    ccw <= 1'h1;
    settle(200);
    check(32'(direction_o), 32'h0000_0000);
    ccw <= 1'h0;
  endtask

  task automatic t_fault();
    settle(2 * GATE + 20);
    check(32'(fault_o), 32'h0000_0000);
    supply_ok <= 1'h0;
    wr(OFS_CTRL, 32'h0000_0001 << CF_TTL);
    settle(10);
    check(32'(fault_o), 32'h0000_0001);
    supply_ok <= 1'h1;
    settle(10);
    check(32'(fault_o), 32'h0000_0000);
    sincos_ok <= 1'h0;
    wr(OFS_CTRL, 32'h0000_0001 << CF_SINCOS);
    settle(10);
    check(32'(fault_o), 32'h0000_0001);
    wr(OFS_CTRL, (32'h0000_0001 << CF_SINCOS) | (32'h0000_0001 << CF_ANA_DIS));
    settle(10);
    check(32'(fault_o), 32'h0000_0000);
    sincos_ok <= 1'h1;
    wr(OFS_CTRL, 32'h0000_0000);
    glitch <= 1'h1;
    settle(2 * GATE + 20);
    check(32'(fault_o), 32'h0000_0001);
    // a fault alone never lifts the under-limit output, so user logic must gate on fault_o
    check(32'(under_limit_o), 32'h0000_0000);
    glitch <= 1'h0;
    settle(2 * GATE + 20);
    check(32'(fault_o), 32'h0000_0000);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    t_reset();
    t_hyst();
    formula(32'h0000_0000, 32'h0000_0064, 32'h0000_0006, 32'h0000_0001, 32'h0000_0000,
            32'h0000_000A, 32'h0000_000A);
    formula(32'h0000_0008, 32'h0000_0003, 32'h0000_0064, 32'h0000_0032, 32'h0000_0014,
            32'h0000_0064, 32'h0000_0050);
    formula(32'h0000_0018, 32'h0000_0002, 32'h0000_0028, 32'h0000_0001, 32'h0000_007F,
            32'h0000_0032, 32'h0000_0000);
    t_select();
    t_dir();
    t_fault();
    give_verdict();
  end

  // the full sequence needs about 60000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
